//--- logic/tqar_regs.sv
// transmit queue address register bank with pending queue pointers
`timescale 1ns/10ps
// Function
// R1: queue address is base shifted 14 above offset shifted one, upper 23 bits.
// R2: pending queue start address comes from the start offset register.
// R3: pending queue end address comes from the end offset register.
// R4: bit zero of every start, end and pointer address is forced low.
// R5: host posts a descriptor address at the write pointer, then advances it.
// R6: host write pointer is a 13-bit offset, combined like the start.
// R7: a pointer write with bit 15 set requests auto-increment.
// R8: auto-increment advances the pointer one entry, ignoring the low data bits. The code holds the pointer instead while the queue is full.
// R9: reading host pointer flags empty when pointers match and queue holds nothing.
// R10: reading host pointer flags full when pointers match and no entry is free.
// R11: device fetches descriptor addresses at its own read pointer address.
// R12: table entry address is base shifted eight plus reference shifted four.
// R13: pointers wrap from the end offset back to the start offset.
module tqar_regs
(
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    input  wire logic [tqar_pkg::ADDR_W-1:0]     regAddr,
    input  wire logic [tqar_pkg::DATA_W-1:0]     regWrData,
    input  wire logic                            regWrStb,
    input  wire logic                            regRdStb,
    output logic [tqar_pkg::DATA_W-1:0]          regRdData,
    input  wire logic [tqar_pkg::CREF_W-1:0]     circuitRef,
    input  wire logic                            fetchDone,
    output logic                                 fetchReq,
    output logic [tqar_pkg::MEM_ADDR_W-1:0]      fetchAddr,
    output logic [tqar_pkg::MEM_ADDR_W-1:0]      hostWrAddr,
    output logic [tqar_pkg::MEM_ADDR_W-1:0]      startAddr,
    output logic [tqar_pkg::MEM_ADDR_W-1:0]      endAddr,
    output logic [tqar_pkg::MEM_ADDR_W-1:0]      crtAddr,
    output logic [tqar_pkg::DATA_W-1:0]          descAddr,
    output logic                                 irq
);
    import tqar_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [DATA_W-1:0]     desc_q;
    logic [DATA_W-1:0]     crtBase_q;
    logic [QBASE_W-1:0]    queueBase_q;
    logic [OFF_W-1:0]      startOff_q;
    logic [OFF_W-1:0]      endOff_q;
    logic [OFF_W-1:0]      hostPtr_q;
    logic [OFF_W-1:0]      readPtr_q;
    logic                  lastWrite_q;
    logic [IRQ_W-1:0]      irqStat_q;
    logic [IRQ_W-1:0]      irqMask_q;
    logic [IRQ_W-1:0]      irqEvt;
    logic [DATA_W-1:0]     rdData_q;
    logic                  fetchReq_q;
    logic [MEM_ADDR_W-1:0] fetchAddr_q;
    logic [MEM_ADDR_W-1:0] crtAddr_q;
    logic [MEM_ADDR_W-1:0] pendAddr_q [4];
    logic [MEM_ADDR_W-1:0] pendAddr_d [4];
    logic [OFF_W-1:0]      pendOff [4];
    logic                  irq_q;
    tqar_fetch_t           fetch_q;
    logic [OFF_W-1:0]      hostPtrNext;
    logic [OFF_W-1:0]      readPtrNext;
    logic                  ptrEqual;
    logic                  qEmpty;
    logic                  qFull;
    logic                  wrHostPtr;
    logic                  autoInc;
    logic                  hostAdvance;
    logic                  devAdvance;
    logic                  wrStart;

    // decode helper shared by the write decode and the read-strobe assertions
    function automatic logic hit(input logic stb, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] r);
        hit = stb && (a == r);
    endfunction : hit

    // ------------------------------------------------------------
    // queue configuration carrier
    // ------------------------------------------------------------
    tqar_qcfg_if qcfg ();
    assign qcfg.queueBase = queueBase_q;
    assign qcfg.startOff  = startOff_q;
    assign qcfg.endOff    = endOff_q;

    // ------------------------------------------------------------
    // pointer stepping
    // ------------------------------------------------------------
    tqar_ptr_step u_hostStep
    (
        .cfg     (qcfg),
        .ptr     (hostPtr_q),
        .nextPtr (hostPtrNext)
    );
    tqar_ptr_step u_readStep
    (
        .cfg     (qcfg),
        .ptr     (readPtr_q),
        .nextPtr (readPtrNext)
    );

    // ------------------------------------------------------------
    // queue state and write decode
    // ------------------------------------------------------------
    // equal pointers are ambiguous, so the last mover decides
    assign ptrEqual    = (hostPtr_q == readPtr_q);
    assign qEmpty      = ptrEqual && !lastWrite_q;         // R9
    assign qFull       = ptrEqual && lastWrite_q;          // R10
    assign wrHostPtr   = hit(regWrStb, regAddr, REG_HWPTR);
    assign autoInc     = wrHostPtr && regWrData[BIT_AUTOINC]; // R7
    // a post into a full queue would silently lose every entry
    assign hostAdvance = autoInc && !qFull;                // R8
    assign devAdvance  = (fetch_q == FETCH_WAIT) && fetchDone;
    assign wrStart     = hit(regWrStb, regAddr, REG_PSTART);

    // ------------------------------------------------------------
    // plain configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            desc_q      <= RST_WORD;
            crtBase_q   <= RST_WORD;
            queueBase_q <= QBASE_W'(RST_WORD);
            startOff_q  <= RST_OFF;
            endOff_q    <= RST_OFF;
            irqMask_q   <= RST_IRQ;
        end
        else
        begin
            if (hit(regWrStb, regAddr, REG_DESC))
                desc_q <= regWrData;
            if (hit(regWrStb, regAddr, REG_CRTBASE))
                crtBase_q <= regWrData;
            if (hit(regWrStb, regAddr, REG_QBASE))
                queueBase_q <= regWrData[QBASE_W-1:0];
            if (wrStart)
                startOff_q <= regWrData[OFF_W-1:0];        // R2
            if (hit(regWrStb, regAddr, REG_PEND))
                endOff_q <= regWrData[OFF_W-1:0];          // R3
            if (hit(regWrStb, regAddr, REG_IRQMASK))
                irqMask_q <= regWrData[IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // host write pointer
    // ------------------------------------------------------------
    // a new start offset restarts the queue at its first entry
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            hostPtr_q <= RST_OFF;
        else if (wrStart)
            hostPtr_q <= regWrData[OFF_W-1:0];
        else if (hostAdvance)
            hostPtr_q <= hostPtrNext;                      // R8
        else if (wrHostPtr && !regWrData[BIT_AUTOINC])
            hostPtr_q <= regWrData[OFF_W-1:0];             // R6
    end

    // ------------------------------------------------------------
    // device read pointer
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            readPtr_q <= RST_OFF;
        else if (wrStart)
            readPtr_q <= regWrData[OFF_W-1:0];
        else if (devAdvance)
            readPtr_q <= readPtrNext;                      // R11
    end

    // ------------------------------------------------------------
    // last mover flag
    // ------------------------------------------------------------
    // moves by both sides in one cycle leave the fill unchanged
    always_ff @(posedge sys_clk)
    begin
        if (rst || wrStart)
            lastWrite_q <= 1'b0;
        else if (hostAdvance && !devAdvance)
            lastWrite_q <= 1'b1;
        else if (devAdvance && !hostAdvance)
            lastWrite_q <= 1'b0;
        else if (wrHostPtr && !regWrData[BIT_AUTOINC])
            lastWrite_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // fetch sequencer
    // ------------------------------------------------------------
    // the address is held for the whole fetch so the dma side
    // never sees it move under a pending request
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            fetch_q     <= FETCH_IDLE;
            fetchReq_q  <= 1'b0;
            fetchAddr_q <= '0;
        end
        else
        begin
            unique case (fetch_q)
                FETCH_IDLE:
                begin
                    if (!qEmpty && !wrStart)
                    begin
                        fetch_q     <= FETCH_WAIT;
                        fetchReq_q  <= 1'b1;
                        fetchAddr_q <= pendAddr_d[3];      // R11
                    end
                end
                FETCH_WAIT:
                begin
                    if (fetchDone)
                    begin
                        fetch_q    <= FETCH_IDLE;
                        fetchReq_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // queue address formation
    // ------------------------------------------------------------
    assign pendOff[0] = startOff_q;
    assign pendOff[1] = endOff_q;
    assign pendOff[2] = hostPtr_q;
    assign pendOff[3] = readPtr_q;

    // start, end, host pointer and read pointer addresses
    for (genvar i = 0; i < 4; i++)
    begin : g_addr
        tqar_addr_form u_form
        (
            .cfg  (qcfg),
            .off  (pendOff[i]),
            .addr (pendAddr_d[i])
        );
        always_ff @(posedge sys_clk)
        begin
            if (rst)
                pendAddr_q[i] <= '0;
            else
                pendAddr_q[i] <= pendAddr_d[i];            // R1
        end
    end

    // ------------------------------------------------------------
    // circuit reference table entry address
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            crtAddr_q <= '0;
        else
            crtAddr_q <= (MEM_ADDR_W'(crtBase_q) << CRT_BASE_SHIFT)
                       + (MEM_ADDR_W'(circuitRef) << CRT_REF_SHIFT); // R12
    end

    // ------------------------------------------------------------
    // interrupt status and output
    // ------------------------------------------------------------
    assign irqEvt[IRQ_POST]  = hostAdvance;
    assign irqEvt[IRQ_OVFL]  = autoInc && qFull;
    assign irqEvt[IRQ_FETCH] = devAdvance;

    // write one to clear; a new event in the same cycle wins
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irqStat_q <= RST_IRQ;
        else if (hit(regWrStb, regAddr, REG_IRQSTAT))
            irqStat_q <= (irqStat_q & ~regWrData[IRQ_W-1:0]) | irqEvt;
        else
            irqStat_q <= irqStat_q | irqEvt;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            irq_q <= 1'b0;
        else
            irq_q <= |((irqStat_q | irqEvt) & irqMask_q);
    end

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    // data stand for one cycle only; unmapped offsets read zero
    always_ff @(posedge sys_clk)
    begin
        if (rst || !regRdStb)
            rdData_q <= RST_WORD;
        else
        begin
            unique case (regAddr)
                REG_DESC:    rdData_q <= desc_q;
                REG_CRTBASE: rdData_q <= crtBase_q;
                REG_QBASE:   rdData_q <= DATA_W'(queueBase_q);
                REG_PSTART:  rdData_q <= DATA_W'(startOff_q);
                REG_PEND:    rdData_q <= DATA_W'(endOff_q);
                REG_HWPTR:   rdData_q <= {1'b0, qEmpty, qFull, hostPtr_q}; // R9 R10
                REG_DRPTR:   rdData_q <= DATA_W'(readPtr_q);
                REG_IRQSTAT: rdData_q <= DATA_W'(irqStat_q);
                REG_IRQMASK: rdData_q <= DATA_W'(irqMask_q);
                default:     rdData_q <= RST_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regRdData  = rdData_q;
    assign fetchReq   = fetchReq_q;
    assign fetchAddr  = fetchAddr_q;
    assign startAddr  = pendAddr_q[0];
    assign endAddr    = pendAddr_q[1];
    assign hostWrAddr = pendAddr_q[2];
    assign crtAddr    = crtAddr_q;
    assign descAddr   = desc_q;
    assign irq        = irq_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_qaddr_upper;
        ##1 hostWrAddr[23:14] == $past(queueBase_q)
            && hostWrAddr[13:1] == $past(hostPtr_q);
    endproperty
    a_qaddr_upper: assert property (p_qaddr_upper) // R1
        else $error("host pointer address not base over offset");

    property p_start_end;
        ##1 startAddr[13:1] == $past(startOff_q) && endAddr[13:1] == $past(endOff_q);
    endproperty
    a_start_end: assert property (p_start_end) // R2
        else $error("start or end address does not follow its register");

    property p_end_load;
        hit(regWrStb, regAddr, REG_PEND) |-> ##2 endAddr[13:1] == $past(regWrData[12:0], 2);
    endproperty
    a_end_load: assert property (p_end_load) // R3
        else $error("end address not updated two cycles after write");

    property p_bit0;
        !startAddr[0] && !endAddr[0] && !hostWrAddr[0] && !fetchAddr[0];
    endproperty
    a_bit0: assert property (p_bit0) // R4
        else $error("queue address bit zero is set");

    property p_ptr_load;
        wrHostPtr && !regWrData[BIT_AUTOINC] && !wrStart
            |=> hostPtr_q == $past(regWrData[12:0]);
    endproperty
    a_ptr_load: assert property (p_ptr_load) // R6
        else $error("plain pointer write not stored");

    property p_auto_inc;
        autoInc && !qFull |=> hostPtr_q == (($past(hostPtr_q) == $past(endOff_q))
            ? $past(startOff_q) : OFF_W'($past(hostPtr_q) + 13'h0001));
    endproperty
    a_auto_inc: assert property (p_auto_inc) // R8
        else $error("auto increment did not step or wrap the pointer");

    property p_empty_rd;
        hit(regRdStb, regAddr, REG_HWPTR) && qEmpty
            |=> regRdData[BIT_EMPTY] && !regRdData[BIT_FULL];
    endproperty
    a_empty_rd: assert property (p_empty_rd) // R9
        else $error("empty not reported on pointer read");

    property p_full_rd;
        hit(regRdStb, regAddr, REG_HWPTR) && qFull
            |=> regRdData[BIT_FULL] && !regRdData[BIT_EMPTY];
    endproperty
    a_full_rd: assert property (p_full_rd) // R10
        else $error("full not reported on pointer read");

    property p_fetch_hold;
        fetchReq && !fetchDone |=> fetchReq && $stable(fetchAddr);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) // R11
        else $error("fetch address moved during a pending fetch");

    // a new request must carry the registered read pointer address
    property p_fetch_addr;
        $rose(fetchReq) |-> fetchAddr == pendAddr_q[3];
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) // R11
        else $error("fetch address is not the read pointer address");

    // the first edge out of reset still holds a cleared address
    property p_crt;
        !rst |=> crtAddr == (MEM_ADDR_W'($past(crtBase_q)) << CRT_BASE_SHIFT)
            + (MEM_ADDR_W'($past(circuitRef)) << CRT_REF_SHIFT);
    endproperty
    a_crt: assert property (p_crt) // R12
        else $error("circuit table entry address wrong");

    c_fill_full: cover property (autoInc ##[1:50] qFull);
    c_wrap: cover property (devAdvance && readPtr_q == endOff_q);
    c_irq: cover property (!irq ##1 irq);
endmodule : tqar_regs

//--- logic/tqar_pkg.sv
// constants and types shared by the transmit queue address register bank
package tqar_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W     = 4;
    localparam int DATA_W     = 16;
    localparam int OFF_W      = 13;
    localparam int QBASE_W    = 10;
    localparam int CREF_W     = 10;
    localparam int MEM_ADDR_W = 24;
    localparam int IRQ_W      = 3;
    // ------------------------------------------------------------
    // register offsets (word index on the control port)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_DESC    = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CRTBASE = 4'h1;
    localparam logic [ADDR_W-1:0] REG_QBASE   = 4'h2;
    localparam logic [ADDR_W-1:0] REG_PSTART  = 4'h3;
    localparam logic [ADDR_W-1:0] REG_PEND    = 4'h4;
    localparam logic [ADDR_W-1:0] REG_HWPTR   = 4'h5;
    localparam logic [ADDR_W-1:0] REG_DRPTR   = 4'h6;
    localparam logic [ADDR_W-1:0] REG_IRQSTAT = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IRQMASK = 4'h8;
    // ------------------------------------------------------------
    // field positions, shifts and reset values
    // ------------------------------------------------------------
    localparam int BIT_AUTOINC    = 15;
    localparam int BIT_EMPTY      = 14;
    localparam int BIT_FULL       = 13;
    localparam int QBASE_SHIFT    = 14;
    localparam int OFF_SHIFT      = 1;
    localparam int CRT_BASE_SHIFT = 8;
    localparam int CRT_REF_SHIFT  = 4;
    localparam int IRQ_POST       = 0;
    localparam int IRQ_OVFL       = 1;
    localparam int IRQ_FETCH      = 2;
    localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
    localparam logic [OFF_W-1:0]  RST_OFF  = 13'h0000;
    localparam logic [IRQ_W-1:0]  RST_IRQ  = 3'h0;
    // ------------------------------------------------------------
    // fetch sequencer states
    // ------------------------------------------------------------
    typedef enum logic {FETCH_IDLE, FETCH_WAIT} tqar_fetch_t;
endpackage : tqar_pkg

//--- logic/tqar_qcfg_if.sv
// interface carrying the queue base and the pending queue bounds
`timescale 1ns/10ps
interface tqar_qcfg_if;
    import tqar_pkg::*;
    logic [QBASE_W-1:0] queueBase;
    logic [OFF_W-1:0]   startOff;
    logic [OFF_W-1:0]   endOff;
    modport owner (output queueBase, output startOff, output endOff);
    modport user  (input queueBase, input startOff, input endOff);
endinterface : tqar_qcfg_if

//--- logic/tqar_addr_form.sv
// forms a 24-bit halfword aligned queue address from base and offset
`timescale 1ns/10ps
module tqar_addr_form
(
    tqar_qcfg_if.user                       cfg,
    input  wire logic [tqar_pkg::OFF_W-1:0] off,
    output logic [tqar_pkg::MEM_ADDR_W-1:0] addr
);
    import tqar_pkg::*;
    // ------------------------------------------------------------
    // base above offset, bit zero always low
    // ------------------------------------------------------------
    logic [MEM_ADDR_W-1:0] basePart;
    logic [MEM_ADDR_W-1:0] offPart;
    assign basePart = MEM_ADDR_W'(cfg.queueBase) << QBASE_SHIFT; // R1
    assign offPart  = MEM_ADDR_W'(off) << OFF_SHIFT;              // R1
    // the or keeps bit 0 clear since the offset is shifted by one
    assign addr = (basePart | offPart) & ~24'h000001;             // R4
endmodule : tqar_addr_form

//--- logic/tqar_ptr_step.sv
// advances a queue pointer one entry, wrapping at the end offset
`timescale 1ns/10ps
module tqar_ptr_step
(
    tqar_qcfg_if.user                       cfg,
    input  wire logic [tqar_pkg::OFF_W-1:0] ptr,
    output logic [tqar_pkg::OFF_W-1:0]      nextPtr
);
    import tqar_pkg::*;
    // ------------------------------------------------------------
    // circular step
    // ------------------------------------------------------------
    // compare for equality only: a pointer set beyond the end by
    // software runs on up to the 13-bit limit before wrapping
    assign nextPtr = (ptr == cfg.endOff) ? cfg.startOff
                                         : OFF_W'(ptr + 13'h0001); // R13
endmodule : tqar_ptr_step

//--- bench/tqar_dma_model.sv
// behavioural descriptor fetch responder on the fetch link of the bank
`timescale 1ns/10ps
module tqar_dma_model
#(
    parameter int DLY = 2
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic fetchReq,
    input  wire logic stall,
    output logic      fetchDone
);
    int waitCnt_q;
    // answer DLY+1 cycles after the request rises; stall withholds the answer so the queue can fill up
    always_ff @(posedge sys_clk)
    begin
        if (rst || !fetchReq || fetchDone)
        begin
            fetchDone <= 1'b0;
            waitCnt_q <= 0;
        end
        else if (!stall && waitCnt_q == DLY)
            fetchDone <= 1'b1;
        else if (!stall)
            waitCnt_q <= waitCnt_q + 1;
    end
endmodule : tqar_dma_model

//--- bench/tqar_regs_bench.sv
// self-checking bench for the transmit queue address register bank
`timescale 1ns/10ps
module tqar_regs_bench;
    import tqar_pkg::*;
    typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] w; logic [DATA_W-1:0] e;} tqar_row_t;
    localparam logic [9:0] QB = 10'h2A5;
    logic                  sys_clk, rst, regWrStb, regRdStb, fetchDone, fetchReq, irq, stall;
    logic [ADDR_W-1:0]     regAddr;
    logic [DATA_W-1:0]     regWrData, regRdData, descAddr;
    logic [CREF_W-1:0]     circuitRef;
    logic [MEM_ADDR_W-1:0] fetchAddr, hostWrAddr, startAddr, endAddr, crtAddr;
    tqar_row_t             rows[8];
    int                    err_total = 0;
    int                    n_checks = 0;
    // ------------------------------------------------------------
    // clock, design and fetch responder
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    tqar_regs dut_u (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .circuitRef(circuitRef), .fetchDone(fetchDone), .fetchReq(fetchReq),
        .fetchAddr(fetchAddr), .hostWrAddr(hostWrAddr), .startAddr(startAddr),
        .endAddr(endAddr), .crtAddr(crtAddr), .descAddr(descAddr), .irq(irq));
    tqar_dma_model #(.DLY(2)) dma_u (.sys_clk(sys_clk), .rst(rst), .fetchReq(fetchReq),
        .stall(stall), .fetchDone(fetchDone));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [23:0] qa(input logic [12:0] off);
        return {QB, off, 1'b0};
    endfunction : qa
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // one-cycle strobes; the lowering edge is never reused by the next access
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrStb  <= 1'b1;
        @(posedge sys_clk);
        regWrStb  <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1;
        chk({8'h00, regRdData}, {8'h00, e});
    endtask : rd
    task automatic wait_req(input logic v);
        for (int i = 0; i < 50 && fetchReq !== v; i++)
            tick(1);
        if (fetchReq !== v)
        begin
            err_total++;
            $display("unexpected at %0t: fetch handshake stuck", $time);
            end_of_test();
        end
    endtask : wait_req
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1; regAddr = '0; regWrData = '0; regWrStb = 1'b0; regRdStb = 1'b0;
        stall = 1'b1;
        circuitRef = 10'h3FF;
        rows = '{'{REG_DESC, 16'hBEEF, 16'hBEEF}, '{REG_CRTBASE, 16'h1234, 16'h1234},
            '{REG_QBASE, 16'hFFFF, 16'h03FF}, '{4'hF, 16'h5555, 16'h0000},
            '{REG_IRQMASK, 16'h0007, 16'h0007}, '{REG_QBASE, 16'h02A5, 16'h02A5},
            '{REG_PSTART, 16'h0003, 16'h0003}, '{REG_PEND, 16'h0005, 16'h0005}};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk({22'h0, irq, fetchReq}, 24'h0);
        chk(hostWrAddr, 24'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        tick(2);
        chk(startAddr, qa(13'h3));
        chk(endAddr, qa(13'h5));
        chk(hostWrAddr, qa(13'h3));
        chk(crtAddr, 24'h123400 + 24'h003FF0);
        chk({8'h00, descAddr}, 24'h00BEEF);
        @(posedge sys_clk);
        circuitRef <= 10'h001;
        tick(2);
        chk(crtAddr, 24'h123410);
        rd(REG_HWPTR, 16'h4003);
        // fill the queue while the fetch side stalls
        wr(REG_HWPTR, 16'h8ABC);
        tick(2);
        chk(hostWrAddr, qa(13'h4));
        chk({23'h0, fetchReq}, 24'h1);
        chk(fetchAddr, qa(13'h3));
        wr(REG_HWPTR, 16'h8000);
        wr(REG_HWPTR, 16'h8000);
        rd(REG_HWPTR, 16'h2003);
        wr(REG_HWPTR, 16'h8000);
        rd(REG_HWPTR, 16'h2003);
        rd(REG_IRQSTAT, 16'h0003);
        chk({23'h0, irq}, 24'h1);
        // drain: fetch addresses walk the queue, then the read pointer wraps
        stall <= 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            wait_req(1'b1);
            chk(fetchAddr, qa(13'(3 + i)));
            wait_req(1'b0);
        end
        tick(2);
        rd(REG_HWPTR, 16'h4003);
        rd(REG_DRPTR, 16'h0003);
        rd(REG_IRQSTAT, 16'h0007);
        // mask, unmask, then clear by writing ones
        wr(REG_IRQMASK, 16'h0000);
        tick(2);
        chk({23'h0, irq}, 24'h0);
        wr(REG_IRQMASK, 16'h0007);
        tick(2);
        chk({23'h0, irq}, 24'h1);
        wr(REG_IRQSTAT, 16'h0007);
        tick(2);
        chk({23'h0, irq}, 24'h0);
        rd(REG_IRQSTAT, 16'h0000);
        // reset in mid-run empties the queue again
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        chk(hostWrAddr, 24'h0);
        rd(REG_HWPTR, 16'h4000);
        // plain pointer write leaves the pointers apart, so no flag
        wr(REG_HWPTR, 16'h0002);
        rd(REG_HWPTR, 16'h0002);
        end_of_test();
    end
endmodule : tqar_regs_bench
